//--- rtl/dhi_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhi_cfg.svh"
// Contract
// (R1) Host dummy-reads before first RAM read
// (R2) Parallel select high RAM, low command/status
// (R3) 4-wire: 8 bits MSB first, rising edge
// (R4) 4-wire: select sampled on eighth clock
// (R5) 3-wire: 9 bits, flag first
// (R6) 3-wire flag routes byte RAM/command
// (R7) Two-wire: slave only, read and write
// (R8) Data stable while clock high
// (R9) Start/stop are data edges, clock high
// (R10) Master starts on idle bus, stops
// (R11) Slave acks every received byte
// (R12) Master nacks last byte; slave releases
// (R13) Address upper six fixed, LSB strap
// (R14) Ack only own address, ignore others
// (R15) Control byte pairs; cleared continuation ends
// (R16) Flag 1 stores RAM, pointer advances
// (R17) Flag 0 bytes decoded as commands
// (R18) Read returns per last write flag
// (R19) Stop sending after master nack
// (R20) Parallel latches on strobes, select low
// (R21) Column advances after each data access
// (R22) Straps select the active link
module dhi_dev (
  input wire logic clk,
  input wire logic rstn,
  dhi_if.dev lnk,
  input wire logic link_select_strap_0,
  input wire logic link_select_strap_1,
  input wire logic link_select_strap_2,
  input wire logic slave_address_lsb_strap,
  input wire logic [7:0] ram_rdata,
  input wire logic [7:0] status_byte,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic wr_is_data,
  output logic rd_fetch,
  output logic [7:0] col_addr
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`DHI_SYNC_W-1:0] pin_raw;
  logic [`DHI_SYNC_W-1:0] meta_reg;
  logic [`DHI_SYNC_W-1:0] sync_reg;
  logic [`DHI_SYNC_W-1:0] prev_reg;
  assign pin_raw = {lnk.d, slave_address_lsb_strap, link_select_strap_2,
    link_select_strap_1, link_select_strap_0, lnk.sda, lnk.si, lnk.scl,
    lnk.dcs, lnk.wr_n, lnk.rd_n, lnk.cs_n};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end else begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end
  logic cs_n_s, rd_n_s, wr_n_s, dcs_s, scl_s, si_s, sda_s, sa0_s;
  logic [7:0] d_s;
  assign cs_n_s = sync_reg[0];
  assign rd_n_s = sync_reg[1];
  assign wr_n_s = sync_reg[2];
  assign dcs_s = sync_reg[3];
  assign scl_s = sync_reg[4];
  assign si_s = sync_reg[5];
  assign sda_s = sync_reg[6];
  assign sa0_s = sync_reg[10];
  assign d_s = sync_reg[18:11];
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~prev_reg[4];
  assign scl_fall = ~scl_s & prev_reg[4];
  assign start_c = scl_s & prev_reg[4] & ~sda_s & prev_reg[6]; // (R9)
  assign stop_c = scl_s & prev_reg[4] & sda_s & ~prev_reg[6]; // (R9)
  // ----------------------------------------
  // Link selection
  // ----------------------------------------
  function automatic dhi_pkg::dhi_link_t dhi_decode(input logic [2:0] s);
    case (s)
      `DHI_STRAP_PAR: dhi_decode = dhi_pkg::DHI_PAR;
      `DHI_STRAP_SPI4: dhi_decode = dhi_pkg::DHI_SPI4;
      `DHI_STRAP_SPI3: dhi_decode = dhi_pkg::DHI_SPI3;
      `DHI_STRAP_I2C: dhi_decode = dhi_pkg::DHI_I2C;
      default: dhi_decode = dhi_pkg::DHI_NONE;
    endcase
  endfunction : dhi_decode
  dhi_pkg::dhi_link_t mode_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= dhi_pkg::DHI_NONE;
    end else begin
      mode_reg <= dhi_decode(sync_reg[9:7]); // (R22)
    end
  end
  // ----------------------------------------
  // Parallel bus
  // ----------------------------------------
  logic par_wr, par_rd_end;
  logic [7:0] rdlat_reg, dd_o_reg;
  logic dd_oe_reg;
  assign par_wr = mode_reg == dhi_pkg::DHI_PAR & wr_n_s & ~prev_reg[2]
    & ~prev_reg[0]; // (R20)
  assign par_rd_end = mode_reg == dhi_pkg::DHI_PAR & rd_n_s & ~prev_reg[1]
    & ~prev_reg[0] & dcs_s;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdlat_reg <= 8'h00;
      dd_o_reg <= 8'h00;
      dd_oe_reg <= 1'b0;
    end else begin
      dd_oe_reg <= mode_reg == dhi_pkg::DHI_PAR & ~cs_n_s & ~rd_n_s; // (R20)
      dd_o_reg <= dcs_s ? rdlat_reg : status_byte; // (R2)
      // Pipeline latch: a read shows the previous fetch
      if (par_rd_end) begin
        rdlat_reg <= ram_rdata; // (R1)
      end
    end
  end
  assign lnk.dd_o = dd_o_reg;
  assign lnk.dd_oe = dd_oe_reg;
  // ----------------------------------------
  // Serial shift links
  // ----------------------------------------
  logic [3:0] sbit_reg;
  logic [7:0] ssh_reg;
  logic spi_done, spi_on;
  assign spi_on = (mode_reg == dhi_pkg::DHI_SPI4
    | mode_reg == dhi_pkg::DHI_SPI3) & ~cs_n_s;
  assign spi_done = spi_on & scl_rise
    & ((mode_reg == dhi_pkg::DHI_SPI4 & sbit_reg == `DHI_SPI4_LAST)
    | (mode_reg == dhi_pkg::DHI_SPI3 & sbit_reg == `DHI_SPI3_LAST));
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sbit_reg <= 4'h0;
      ssh_reg <= 8'h00;
    end else if (!spi_on) begin
      sbit_reg <= 4'h0;
    end else if (scl_rise) begin
      ssh_reg <= {ssh_reg[6:0], si_s}; // (R3) (R5)
      sbit_reg <= spi_done ? 4'h0 : sbit_reg + 4'h1;
    end
  end
  // ----------------------------------------
  // Two-wire slave
  // ----------------------------------------
  dhi_pkg::dhi_slv_t ist_reg;
  logic [3:0] ibit_reg;
  logic [7:0] ish_reg, txsh_reg;
  logic rw_reg, ctrl_next_reg, co_reg, i2c_dc_reg, sda_oe_reg;
  logic i2c_emit, i2c_fetch, addr_hit;
  assign addr_hit = ish_reg[7:1] == {`DHI_I2C_ADDR_HI, sa0_s}; // (R13)
  assign i2c_emit = ist_reg == dhi_pkg::I_RX & scl_fall
    & ibit_reg == `DHI_I2C_ACK_BIT & ~ctrl_next_reg;
  assign i2c_fetch = ist_reg == dhi_pkg::I_WACK & scl_fall & rw_reg
    & i2c_dc_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ist_reg <= dhi_pkg::I_IDLE;
      ibit_reg <= 4'h0;
      ish_reg <= 8'h00;
      txsh_reg <= 8'h00;
      rw_reg <= 1'b0;
      ctrl_next_reg <= 1'b1;
      co_reg <= 1'b0;
      i2c_dc_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (mode_reg != dhi_pkg::DHI_I2C || stop_c) begin
      ist_reg <= dhi_pkg::I_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_c) begin
      ist_reg <= dhi_pkg::I_ADDR; // (R7)
      ibit_reg <= 4'h0;
      ctrl_next_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
    end else begin
      case (ist_reg)
        dhi_pkg::I_ADDR, dhi_pkg::I_RX: begin
          // Bits are taken on the rising edge, stable while high
          if (scl_rise) begin
            ish_reg <= {ish_reg[6:0], sda_s}; // (R8)
            ibit_reg <= ibit_reg + 4'h1;
          end else if (scl_fall && ibit_reg == `DHI_I2C_ACK_BIT) begin
            ibit_reg <= 4'h0;
            if (ist_reg == dhi_pkg::I_ADDR && !addr_hit) begin
              ist_reg <= dhi_pkg::I_IGN; // (R14)
            end else begin
              sda_oe_reg <= 1'b1; // (R11)
              ist_reg <= dhi_pkg::I_WACK;
              if (ist_reg == dhi_pkg::I_ADDR) begin
                rw_reg <= ish_reg[0]; // (R14)
              end else if (ctrl_next_reg) begin
                co_reg <= ish_reg[7]; // (R15)
                i2c_dc_reg <= ish_reg[6];
                ctrl_next_reg <= 1'b0;
              end else begin
                ctrl_next_reg <= co_reg; // (R15)
              end
            end
          end
        end
        dhi_pkg::I_WACK: begin
          if (scl_fall) begin
            ibit_reg <= 4'h0;
            if (rw_reg) begin
              // Flag of the last write picks the source
              sda_oe_reg <= ~(i2c_dc_reg ? ram_rdata[7] : status_byte[7]);
              txsh_reg <= (i2c_dc_reg ? ram_rdata : status_byte) << 1; // (R18)
              ist_reg <= dhi_pkg::I_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              ist_reg <= dhi_pkg::I_RX;
            end
          end
        end
        dhi_pkg::I_TX: begin
          if (scl_fall) begin
            if (ibit_reg == `DHI_SPI4_LAST) begin
              sda_oe_reg <= 1'b0; // (R12)
              ist_reg <= dhi_pkg::I_TACK;
            end else begin
              sda_oe_reg <= ~txsh_reg[7];
              txsh_reg <= txsh_reg << 1;
              ibit_reg <= ibit_reg + 4'h1;
            end
          end
        end
        dhi_pkg::I_TACK: begin
          if (scl_rise) begin
            ist_reg <= sda_s ? dhi_pkg::I_IGN : dhi_pkg::I_WACK; // (R19)
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end
  assign lnk.sda_d_oe = sda_oe_reg;
  // ----------------------------------------
  // Byte output and column counter
  // ----------------------------------------
  logic wr_valid_reg, wr_is_data_reg, rd_fetch_reg;
  logic [7:0] wr_byte_reg, col_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_valid_reg <= 1'b0;
      wr_byte_reg <= 8'h00;
      wr_is_data_reg <= 1'b0;
    end else begin
      wr_valid_reg <= par_wr | spi_done | i2c_emit;
      if (par_wr) begin
        wr_byte_reg <= d_s;
        wr_is_data_reg <= dcs_s; // (R2)
      end else if (spi_done) begin
        wr_byte_reg <= {ssh_reg[6:0], si_s};
        wr_is_data_reg <= mode_reg == dhi_pkg::DHI_SPI4 ? dcs_s // (R4)
          : ssh_reg[7]; // (R6)
      end else if (i2c_emit) begin
        wr_byte_reg <= ish_reg;
        wr_is_data_reg <= i2c_dc_reg; // (R16) (R17)
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_fetch_reg <= 1'b0;
      col_reg <= 8'h00;
    end else begin
      rd_fetch_reg <= par_rd_end | i2c_fetch;
      if ((wr_valid_reg & wr_is_data_reg) | par_rd_end | i2c_fetch) begin
        col_reg <= col_reg + 8'h01; // (R16) (R21)
      end
    end
  end
  assign wr_valid = wr_valid_reg;
  assign wr_byte = wr_byte_reg;
  assign wr_is_data = wr_is_data_reg;
  assign rd_fetch = rd_fetch_reg;
  assign col_addr = col_reg;
endmodule : dhi_dev
`default_nettype wire

//--- rtl/dhi_cfg.svh
`ifndef DHI_CFG_SVH
`define DHI_CFG_SVH
// ----------------------------------------
// Strap codes {strap_2, strap_1, strap_0}
// ----------------------------------------
`define DHI_STRAP_PAR 3'h6
`define DHI_STRAP_SPI4 3'h0
`define DHI_STRAP_SPI3 3'h1
`define DHI_STRAP_I2C 3'h2
// ----------------------------------------
// Link layout and timing
// ----------------------------------------
`define DHI_I2C_ADDR_HI 6'h1E
`define DHI_SYNC_W 19
`define DHI_SPI4_LAST 4'h7
`define DHI_SPI3_LAST 4'h8
`define DHI_I2C_ACK_BIT 4'h8
`define DHI_FRAME_W 27
`define DHI_I2C_WR_BITS 5'h1B
`define DHI_I2C_RD_BITS 5'h12
`define DHI_SPI4_BITS 5'h08
`define DHI_SPI3_BITS 5'h09
`define DHI_QTR_CYC 8'h04
`define DHI_STRB_CYC 8'h08
`endif

//--- rtl/dhi_pkg.sv
package dhi_pkg;
  typedef enum logic [2:0] {
    DHI_PAR, DHI_SPI4, DHI_SPI3, DHI_I2C, DHI_NONE
  } dhi_link_t;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_WACK, I_RX, I_TX, I_TACK, I_IGN
  } dhi_slv_t;
  typedef enum logic [2:0] {
    H_IDLE, H_PAR, H_START, H_BIT, H_STOP
  } dhi_hst_t;
endpackage : dhi_pkg

//--- rtl/dhi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dhi_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic dcs;
  logic [7:0] hd_o;
  logic hd_oe;
  logic [7:0] dd_o;
  logic dd_oe;
  logic [7:0] d;
  logic scl;
  logic si;
  logic sda_h_oe;
  logic sda_d_oe;
  logic sda;
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  assign d = dd_oe ? dd_o : (hd_oe ? hd_o : 8'hFF);
  assign sda = ~(sda_h_oe | sda_d_oe);
  modport dev (input cs_n, rd_n, wr_n, dcs, d, scl, si, sda,
    output dd_o, dd_oe, sda_d_oe);
  modport host (output cs_n, rd_n, wr_n, dcs, hd_o, hd_oe, scl, si,
    sda_h_oe, input d, sda);
endinterface : dhi_if
`default_nettype wire

//--- rtl/dhi_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhi_cfg.svh"
module dhi_host (
  input wire logic clk,
  input wire logic rstn,
  dhi_if.host lnk,
  input wire logic req,
  input wire dhi_pkg::dhi_link_t req_link,
  input wire logic req_read,
  input wire logic req_dc,
  input wire logic [7:0] req_wdata,
  input wire logic sa0,
  output logic busy,
  output logic done,
  output logic nacked,
  output logic [7:0] rdata
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [8:0] hmeta_reg, hsync_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hmeta_reg <= 9'h1FF;
      hsync_reg <= 9'h1FF;
    end else begin
      hmeta_reg <= {lnk.d, lnk.sda};
      hsync_reg <= hmeta_reg;
    end
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  dhi_pkg::dhi_hst_t st_reg;
  dhi_pkg::dhi_link_t link_reg;
  logic [7:0] qc_reg, rx_reg, hd_o_reg, rdata_reg;
  logic [1:0] ph_reg;
  logic [`DHI_FRAME_W-1:0] bits_reg;
  logic [4:0] nb_reg;
  logic [3:0] by_reg;
  logic rd_reg, dummy_need_reg, again_reg, busy_reg, done_reg, nack_reg;
  logic cs_n_reg, rd_n_reg, wr_n_reg, dcs_reg, hd_oe_reg, scl_reg, si_reg;
  logic sda_oe_reg, tick, is_i2c;
  assign tick = qc_reg == 8'h00;
  assign is_i2c = link_reg == dhi_pkg::DHI_I2C;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= dhi_pkg::H_IDLE;
      link_reg <= dhi_pkg::DHI_NONE;
      qc_reg <= 8'h00;
      ph_reg <= 2'h0;
      bits_reg <= '0;
      nb_reg <= 5'h00;
      by_reg <= 4'h0;
      rx_reg <= 8'h00;
      rd_reg <= 1'b0;
      dummy_need_reg <= 1'b1;
      again_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      dcs_reg <= 1'b0;
      hd_o_reg <= 8'h00;
      hd_oe_reg <= 1'b0;
      scl_reg <= 1'b1;
      si_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      qc_reg <= tick ? `DHI_QTR_CYC - 8'h01 : qc_reg - 8'h01;
      case (st_reg)
        dhi_pkg::H_IDLE: begin
          if (req) begin
            busy_reg <= 1'b1;
            nack_reg <= 1'b0;
            link_reg <= req_link;
            rd_reg <= req_read;
            dcs_reg <= req_dc;
            ph_reg <= 2'h0;
            by_reg <= 4'h0;
            cs_n_reg <= 1'b0;
            if (req_link == dhi_pkg::DHI_PAR) begin
              qc_reg <= `DHI_STRB_CYC - 8'h01;
              rd_n_reg <= ~req_read;
              wr_n_reg <= req_read;
              hd_o_reg <= req_wdata;
              hd_oe_reg <= ~req_read;
              again_reg <= req_read & req_dc & dummy_need_reg; // (R1)
              dummy_need_reg <= ~(req_read & req_dc) | dummy_need_reg
                & ~req_read;
              st_reg <= dhi_pkg::H_PAR;
            end else if (req_link == dhi_pkg::DHI_I2C) begin
              cs_n_reg <= 1'b1;
              sda_oe_reg <= 1'b1; // (R9) (R10)
              nb_reg <= req_read ? `DHI_I2C_RD_BITS : `DHI_I2C_WR_BITS;
              bits_reg <= req_read
                ? {`DHI_I2C_ADDR_HI, sa0, 2'h3, 8'hFF, 1'b1, 9'h000}
                : {`DHI_I2C_ADDR_HI, sa0, 2'h1, 1'b0, req_dc, 6'h00, 1'b1,
                  req_wdata, 1'b1}; // (R15)
              st_reg <= dhi_pkg::H_START;
            end else begin
              scl_reg <= 1'b0;
              nb_reg <= req_link == dhi_pkg::DHI_SPI4 ? `DHI_SPI4_BITS
                : `DHI_SPI3_BITS;
              bits_reg <= req_link == dhi_pkg::DHI_SPI4
                ? {req_wdata, 19'h00000} : {req_dc, req_wdata, 18'h00000};
              st_reg <= dhi_pkg::H_BIT;
            end
          end
        end
        dhi_pkg::H_PAR: begin
          if (tick) begin
            qc_reg <= `DHI_STRB_CYC - 8'h01;
            if (ph_reg == 2'h0) begin
              rd_n_reg <= 1'b1;
              wr_n_reg <= 1'b1;
              rdata_reg <= hsync_reg[8:1];
              ph_reg <= 2'h1;
            end else if (again_reg) begin
              again_reg <= 1'b0;
              rd_n_reg <= 1'b0;
              ph_reg <= 2'h0;
            end else begin
              cs_n_reg <= 1'b1;
              hd_oe_reg <= 1'b0;
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              st_reg <= dhi_pkg::H_IDLE;
            end
          end
        end
        dhi_pkg::H_START: begin
          if (tick) begin
            scl_reg <= 1'b0;
            st_reg <= dhi_pkg::H_BIT;
          end
        end
        dhi_pkg::H_BIT: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: begin
                si_reg <= bits_reg[`DHI_FRAME_W-1];
                sda_oe_reg <= is_i2c & ~bits_reg[`DHI_FRAME_W-1]; // (R8)
              end
              2'h1: scl_reg <= 1'b1;
              2'h2: begin
                if (is_i2c && by_reg == `DHI_I2C_ACK_BIT
                    && !(rd_reg && nb_reg == 5'h01) && hsync_reg[0]) begin
                  nack_reg <= 1'b1;
                end
                if (is_i2c && rd_reg && nb_reg <= 5'h09
                    && by_reg != `DHI_I2C_ACK_BIT) begin
                  rx_reg <= {rx_reg[6:0], hsync_reg[0]};
                end
              end
              default: begin
                scl_reg <= 1'b0;
                bits_reg <= bits_reg << 1;
                nb_reg <= nb_reg - 5'h01;
                by_reg <= by_reg == `DHI_I2C_ACK_BIT ? 4'h0 : by_reg + 4'h1;
                if (nb_reg == 5'h01) begin
                  if (is_i2c) begin
                    st_reg <= dhi_pkg::H_STOP; // (R12)
                  end else begin
                    scl_reg <= 1'b1;
                    cs_n_reg <= 1'b1;
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    st_reg <= dhi_pkg::H_IDLE;
                  end
                end
              end
            endcase
          end
        end
        dhi_pkg::H_STOP: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            if (ph_reg == 2'h0) begin
              sda_oe_reg <= 1'b1;
            end else if (ph_reg == 2'h1) begin
              scl_reg <= 1'b1;
            end else begin
              sda_oe_reg <= 1'b0; // (R9) (R10)
              rdata_reg <= rx_reg;
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
              st_reg <= dhi_pkg::H_IDLE;
            end
          end
        end
        default: st_reg <= dhi_pkg::H_IDLE;
      endcase
    end
  end
  assign lnk.cs_n = cs_n_reg;
  assign lnk.rd_n = rd_n_reg;
  assign lnk.wr_n = wr_n_reg;
  assign lnk.dcs = dcs_reg;
  assign lnk.hd_o = hd_o_reg;
  assign lnk.hd_oe = hd_oe_reg;
  assign lnk.scl = scl_reg;
  assign lnk.si = si_reg;
  assign lnk.sda_h_oe = sda_oe_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign nacked = nack_reg;
  assign rdata = rdata_reg;
endmodule : dhi_host
`default_nettype wire

//--- test/dhi_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dhi_link_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic hd_oe,
  input wire logic dd_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe
);
  logic in_frame_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Framing on the two-wire bus
  // ----------------------------------------
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_ack_rise;
    sda_d_oe && $rose(scl);
  endsequence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_frame_reg <= 1'b0;
    end else if (scl && $past(scl) && $fell(sda)) begin
      in_frame_reg <= 1'b1;
    end else if (scl && $past(scl) && $rose(sda)) begin
      in_frame_reg <= 1'b0;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_BUS_EXCL: assert property (!(dd_oe && hd_oe))
    else $error("both ends drive the parallel bus");
  AST_RD_DRIVE: assert property ($rose(dd_oe) |-> !cs_n && !rd_n)
    else $error("device drives bus without a read strobe");
  AST_RD_RELEASE: assert property ($rose(rd_n) |-> ##[1:5] !dd_oe)
    else $error("device holds bus after read strobe");
  AST_WR_QUIET: assert property (!wr_n && !cs_n |-> !dd_oe)
    else $error("device drives bus during a write");
  AST_SDA_STABLE: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
    else $error("device moves data line while clock high");
  AST_ACK_HOLD: assert property (s_ack_rise |-> sda_d_oe [*5])
    else $error("device drops data line during clock high");
  AST_FRAME_ONLY: assert property (sda_d_oe |-> in_frame_reg)
    else $error("device pulls data line outside a frame");
  AST_ONE_LINK: assert property (!(sda_d_oe && dd_oe))
    else $error("two links active at once");
  cover property (s_start);
endmodule : dhi_link_monitor
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dhi_cfg.svh"
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] strap = 3'h0;
  logic sa_strap = 1'b1;
  logic [7:0] ram_rdata = 8'hC3;
  logic [7:0] status_byte = 8'h5A;
  logic req = 1'b0;
  dhi_pkg::dhi_link_t req_link = dhi_pkg::DHI_PAR;
  logic req_read = 1'b0;
  logic req_dc = 1'b0;
  logic [7:0] req_wdata = 8'h00;
  logic sa0 = 1'b1;
  logic wr_valid, wr_is_data, rd_fetch, busy, done, nacked;
  logic [7:0] wr_byte, col_addr, rdata;
  int n_fail = 0;
  int n_tests = 0;
  int n_wr = 0;
  int n_fetch = 0;
  int cyc = 0;
  dhi_if lnk_if ();
  dhi_dev dhi_dev_i (.clk(clk), .rstn(rstn), .lnk(lnk_if.dev),
    .link_select_strap_0(strap[0]), .link_select_strap_1(strap[1]),
    .link_select_strap_2(strap[2]), .slave_address_lsb_strap(sa_strap),
    .ram_rdata(ram_rdata), .status_byte(status_byte),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_is_data(wr_is_data),
    .rd_fetch(rd_fetch), .col_addr(col_addr));
  dhi_host dhi_host_i (.clk(clk), .rstn(rstn), .lnk(lnk_if.host),
    .req(req), .req_link(req_link), .req_read(req_read), .req_dc(req_dc),
    .req_wdata(req_wdata), .sa0(sa0), .busy(busy), .done(done),
    .nacked(nacked), .rdata(rdata));
  dhi_link_monitor dhi_link_monitor_i (.clk(clk), .rstn(rstn),
    .cs_n(lnk_if.cs_n), .rd_n(lnk_if.rd_n), .wr_n(lnk_if.wr_n),
    .hd_oe(lnk_if.hd_oe), .dd_oe(lnk_if.dd_oe), .scl(lnk_if.scl),
    .sda(lnk_if.sda), .sda_d_oe(lnk_if.sda_d_oe));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (wr_valid === 1'b1) n_wr++;
    if (rd_fetch === 1'b1) n_fetch++;
    if (cyc == 30000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic mode(input logic [2:0] s);
    @(posedge clk);
    strap <= s;
    repeat (6) @(posedge clk);
  endtask : mode
  task automatic run(input dhi_pkg::dhi_link_t lk, input logic rd,
      input logic dc, input logic [7:0] wd);
    int k;
    @(posedge clk);
    req <= 1'b1;
    req_link <= lk;
    req_read <= rd;
    req_dc <= dc;
    req_wdata <= wd;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    check(busy, 8'h01);
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) n_fail++;
    check(busy, 8'h00);
    repeat (8) @(posedge clk);
    @(negedge clk);
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_par();
    logic [7:0] c0;
    int f0;
    mode(`DHI_STRAP_PAR);
    c0 = col_addr;
    run(dhi_pkg::DHI_PAR, 1'b0, 1'b1, 8'hA5);
    check(wr_byte, 8'hA5);
    check(wr_is_data, 8'h01);
    check(col_addr, c0 + 8'h01);
    run(dhi_pkg::DHI_PAR, 1'b0, 1'b0, 8'h3C);
    check(wr_byte, 8'h3C);
    check(wr_is_data, 8'h00);
    check(col_addr, c0 + 8'h01);
    run(dhi_pkg::DHI_PAR, 1'b1, 1'b0, 8'h00);
    check(rdata, 8'h5A);
    f0 = n_fetch;
    run(dhi_pkg::DHI_PAR, 1'b1, 1'b1, 8'h00);
    check(rdata, 8'hC3);
    check(8'(n_fetch - f0), 8'h02);
    check(col_addr, c0 + 8'h03);
    $display("parallel test done");
  endtask : t_par
  task automatic t_spi();
    dhi_pkg::dhi_link_t lk;
    int w0;
    for (int i = 0; i < 4; i++) begin
      lk = i[1] ? dhi_pkg::DHI_SPI3 : dhi_pkg::DHI_SPI4;
      mode(i[1] ? `DHI_STRAP_SPI3 : `DHI_STRAP_SPI4);
      w0 = n_wr;
      run(lk, 1'b0, i[0], 8'hC5 ^ 8'(i));
      check(wr_byte, 8'hC5 ^ 8'(i));
      check(wr_is_data, 8'(i[0]));
      check(8'(n_wr - w0), 8'h01);
    end
    $display("serial test done");
  endtask : t_spi
  task automatic t_i2c();
    logic [7:0] c0;
    int f0;
    int w0;
    mode(`DHI_STRAP_I2C);
    c0 = col_addr;
    run(dhi_pkg::DHI_I2C, 1'b0, 1'b1, 8'h3A);
    check(nacked, 8'h00);
    check(wr_byte, 8'h3A);
    check(wr_is_data, 8'h01);
    check(col_addr, c0 + 8'h01);
    f0 = n_fetch;
    run(dhi_pkg::DHI_I2C, 1'b1, 1'b1, 8'h00);
    check(rdata, 8'hC3);
    check(8'(n_fetch - f0), 8'h01);
    run(dhi_pkg::DHI_I2C, 1'b0, 1'b0, 8'h81);
    check(wr_is_data, 8'h00);
    run(dhi_pkg::DHI_I2C, 1'b1, 1'b0, 8'h00);
    check(rdata, 8'h5A);
    @(posedge clk);
    sa0 <= 1'b0;
    w0 = n_wr;
    run(dhi_pkg::DHI_I2C, 1'b0, 1'b1, 8'h11);
    check(nacked, 8'h01);
    check(8'(n_wr - w0), 8'h00);
    @(posedge clk);
    sa_strap <= 1'b0;
    mode(`DHI_STRAP_I2C);
    run(dhi_pkg::DHI_I2C, 1'b0, 1'b1, 8'h22);
    check(nacked, 8'h00);
    check(wr_byte, 8'h22);
    w0 = n_wr;
    run(dhi_pkg::DHI_PAR, 1'b0, 1'b1, 8'h77);
    check(8'(n_wr - w0), 8'h00);
    mode(3'h7);
    w0 = n_wr;
    run(dhi_pkg::DHI_PAR, 1'b0, 1'b1, 8'h66);
    check(8'(n_wr - w0), 8'h00);
    $display("two-wire test done");
  endtask : t_i2c
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_par();
    t_spi();
    t_i2c();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
